// ---- design/cbc_params.svh ----
// offsets, field positions, reset values and timing counts of the balance block
`ifndef CBC_PARAMS_SVH
`define CBC_PARAMS_SVH

// register word indices, byte address is four times the index
`define CBC_IDX_CONFIG   6'h13
`define CBC_IDX_ENABLE   6'h14
`define CBC_IDX_TEST     6'h1E
`define CBC_IDX_STATUS   6'h3F

// balance configuration fields
`define CBC_DUR_MSB      7
`define CBC_DUR_LSB      4
`define CBC_KEEP_BIT     3
`define CBC_CFG_MASK     8'hF8
// test configuration field
`define CBC_SQUEEZE_BIT  4

// reset values
`define CBC_CONFIG_RST   8'h00
`define CBC_ENABLE_RST   16'h0000
`define CBC_SQUEEZE_RST  1'h0

// status fields
`define CBC_ST_RUN_BIT   0
`define CBC_ST_BLOCK_BIT 1
`define CBC_ST_CKSUM_BIT 2
`define CBC_ST_SEC_LSB   4
`define CBC_ST_SEC_MSB   15

// widths
`define CBC_CHANNELS     16
`define CBC_FAULT_W      8
`define CBC_SEC_W        12
`define CBC_PRE_W        24

// balance durations in seconds, codes 1 to 9
`define CBC_DUR_1_S      12'h001
`define CBC_DUR_2_S      12'h03C
`define CBC_DUR_3_S      12'h078
`define CBC_DUR_4_S      12'h12C
`define CBC_DUR_5_S      12'h258
`define CBC_DUR_6_S      12'h384
`define CBC_DUR_7_S      12'h4B0
`define CBC_DUR_8_S      12'h708
`define CBC_DUR_9_S      12'hE10
`define CBC_DUR_NONE_S   12'h000

// timing: one-second tick at a 100 ns clock
`define CBC_CLK_PERIOD_NS  100
`define CBC_TICK_PERIOD_NS 1000000000
`define CBC_TICK_CYCLES    (`CBC_TICK_PERIOD_NS / `CBC_CLK_PERIOD_NS)

`endif

// ---- design/cbc_pkg.sv ----
// types and duration decode of the balance block
`include "cbc_params.svh"
package cbc_pkg;
	typedef logic [3:0]               cbc_dur_t;
	typedef logic [`CBC_SEC_W-1:0]    cbc_secs_t;
	typedef logic [`CBC_CHANNELS-1:0] cbc_chan_t;
	typedef enum logic [1:0] {
		cbc_idle,
		cbc_run,
		cbc_done
	} cbc_tstate_e;

	// zero means no timed balancing
	function automatic cbc_secs_t cbc_dur_limit(input cbc_dur_t code);
		unique case (code)
			4'h1:    cbc_dur_limit = `CBC_DUR_1_S;
			4'h2:    cbc_dur_limit = `CBC_DUR_2_S;
			4'h3:    cbc_dur_limit = `CBC_DUR_3_S;
			4'h4:    cbc_dur_limit = `CBC_DUR_4_S;
			4'h5:    cbc_dur_limit = `CBC_DUR_5_S;
			4'h6:    cbc_dur_limit = `CBC_DUR_6_S;
			4'h7:    cbc_dur_limit = `CBC_DUR_7_S;
			4'h8:    cbc_dur_limit = `CBC_DUR_8_S;
			4'h9:    cbc_dur_limit = `CBC_DUR_9_S;
			default: cbc_dur_limit = `CBC_DUR_NONE_S;
		endcase
	endfunction : cbc_dur_limit
endpackage : cbc_pkg

// ---- design/cbc_tick.sv ----
// one-second tick prescaler, restartable
`timescale 1ns/1ps
`include "cbc_params.svh"
module cbc_tick
	import cbc_pkg::*;
#(
	parameter int unsigned CYCLES = `CBC_TICK_CYCLES
) (
	// clock and reset
	input  wire logic i_clock,
	input  wire logic i_srst,
	// control
	input  wire logic i_restart,
	input  wire logic i_run,
	// tick
	output logic      o_tick
);
	localparam logic [`CBC_PRE_W-1:0] LAST = `CBC_PRE_W'(CYCLES - 1);

	logic [`CBC_PRE_W-1:0] count_q;

	always_ff @(posedge i_clock) begin
		if (i_srst || i_restart || !i_run) begin
			count_q <= '0;
		end else if (count_q >= LAST) begin
			count_q <= '0;
		end else begin
			count_q <= count_q + `CBC_PRE_W'(1);
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_srst || i_restart || !i_run) begin
			o_tick <= 1'b0;
		end else begin
			o_tick <= (count_q >= LAST);
		end
	end
endmodule : cbc_tick

// ---- design/cbc_timer.sv ----
// balance auto-stop second counter and its state
`timescale 1ns/1ps
`include "cbc_params.svh"
module cbc_timer
	import cbc_pkg::*;
(
	// clock and reset
	input  wire logic      i_clock,
	input  wire logic      i_srst,
	// control
	input  wire logic      i_restart,
	input  wire logic      i_active,
	input  wire cbc_dur_t  i_code,
	input  wire logic      i_tick,
	// state
	output logic           o_running,
	output logic           o_expire,
	output cbc_secs_t      o_elapsed
);
	cbc_tstate_e state_q;
	cbc_secs_t   limit;
	cbc_secs_t   next_sec;

	assign limit    = cbc_dur_limit(i_code);
	assign next_sec = o_elapsed + `CBC_SEC_W'(1);
	assign o_running = (state_q == cbc_run);

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			state_q   <= cbc_idle;
			o_elapsed <= '0;
			o_expire  <= 1'b0;
		end else begin
			o_expire <= 1'b0;
			unique case (state_q)
				cbc_idle: begin
					o_elapsed <= '0;
					if (i_active && limit != '0) begin
						state_q <= cbc_run;
					end
				end
				cbc_run: begin
					if (!i_active || limit == '0) begin
						state_q   <= cbc_idle;
						o_elapsed <= '0;
					end else if (i_restart) begin
						o_elapsed <= '0;
					end else if (i_tick) begin
						o_elapsed <= next_sec;
						if (next_sec >= limit) begin
							state_q  <= cbc_done;
							o_expire <= 1'b1;
						end
					end
				end
				cbc_done: begin
					if (i_restart) begin
						state_q   <= cbc_run;
						o_elapsed <= '0;
					end else if (!i_active) begin
						state_q   <= cbc_idle;
						o_elapsed <= '0;
					end
				end
			endcase
		end
	end
endmodule : cbc_timer

// ---- design/cbc_top.sv ----
// cell balance control with wishbone register access
//
// Overview of operation
// - duration codes 1 to 9 give 1 s, 1, 2, 5, 10, 15, 20, 30 and 60 min.
// - duration code zero disables the timer, balancing runs until cleared.
// - when the chosen time elapses every channel enable is cleared.
// - the auto-stop timer ignores reads; only enable and config writes and the fault and expiry clears of the enables reach it.
// - an accepted non-zero write to the enables restarts the timer at zero.
// - with keep-on-fault low any fault except checksum clears the enables.
// - with keep-on-fault high faults leave the enables untouched.
// - with keep-on-fault low enable writes are dropped while a fault stands.
// - enable bit n drives balance output n+1 for cell n+1.
// - in squeeze mode the enable bits drive squeeze resistors instead.
// - an enable bit of one turns its channel on, zero turns it off.
// - a squeeze mode bit in the test config selects the squeeze use.
`timescale 1ns/1ps
`include "cbc_params.svh"
module cbc_top
	import cbc_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = `CBC_TICK_CYCLES
) (
	// clock and reset
	input  wire logic        i_clock,
	input  wire logic        i_srst,
	// wishbone slave
	input  wire logic        i_wb_cyc,
	input  wire logic        i_wb_stb,
	input  wire logic        i_wb_we,
	input  wire logic [7:0]  i_wb_adr,
	input  wire logic [3:0]  i_wb_sel,
	input  wire logic [31:0] i_wb_dat,
	output logic             o_wb_ack,
	output logic [31:0]      o_wb_dat,
	// fault sources
	input  wire logic [`CBC_FAULT_W-1:0] i_fault_flags,
	input  wire logic        i_user_checksum_error_flag,
	// switch drives
	output cbc_chan_t        o_balance_output,
	output cbc_chan_t        o_squeeze_output
);
	logic        req;
	logic        wr_req;
	logic [5:0]  idx;
	logic        fault_any;
	logic        keep_on_fault;
	logic        fault_block;
	logic        wr_enable;
	logic        wr_enable_ok;
	logic        wr_config;
	logic        wr_test;
	logic        restart;
	cbc_chan_t   enable_merged;
	cbc_dur_t    dur_code;
	logic [7:0]  config_q;
	cbc_chan_t   enable_q;
	logic        squeeze_q;
	logic        timer_running;
	logic        timer_expire;
	logic        tick;
	cbc_secs_t   elapsed;
	cbc_secs_t   dur_limit;
	logic [31:0] rd_data;

	// decoded limit kept as a net so checks can look back at it
	assign dur_limit = cbc_dur_limit(dur_code);

	// classic wishbone: one request, one ack a cycle later
	assign req    = i_wb_cyc && i_wb_stb && !o_wb_ack;
	assign wr_req = req && i_wb_we;
	assign idx    = i_wb_adr[7:2];

	assign wr_config = wr_req && idx == `CBC_IDX_CONFIG && i_wb_sel[0];
	assign wr_test   = wr_req && idx == `CBC_IDX_TEST && i_wb_sel[0];
	assign wr_enable = wr_req && idx == `CBC_IDX_ENABLE && (|i_wb_sel[1:0]);

	// checksum flag stays out of the fault term by design
	assign fault_any     = |i_fault_flags;
	assign keep_on_fault = config_q[`CBC_KEEP_BIT];
	assign fault_block   = fault_any && !keep_on_fault;
	assign wr_enable_ok  = wr_enable && !fault_block;
	assign dur_code      = config_q[`CBC_DUR_MSB:`CBC_DUR_LSB];

	// byte lanes merge into the 16-bit enable word
	assign enable_merged = {
		i_wb_sel[1] ? i_wb_dat[15:8] : enable_q[15:8],
		i_wb_sel[0] ? i_wb_dat[7:0]  : enable_q[7:0]
	};

	// restart only on a write that really lands and is non-zero
	assign restart = wr_enable_ok && (enable_merged != '0);

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			o_wb_ack <= 1'b0;
		end else begin
			o_wb_ack <= req;
		end
	end

	// reserved low bits never stored
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			config_q <= `CBC_CONFIG_RST;
		end else if (wr_config) begin
			config_q <= i_wb_dat[7:0] & `CBC_CFG_MASK;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			squeeze_q <= `CBC_SQUEEZE_RST;
		end else if (wr_test) begin
			squeeze_q <= i_wb_dat[`CBC_SQUEEZE_BIT];
		end
	end

	// fault clear beats everything; a fresh write beats the expiry
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			enable_q <= `CBC_ENABLE_RST;
		end else if (fault_block) begin
			enable_q <= '0;
		end else if (wr_enable_ok) begin
			enable_q <= enable_merged;
		end else if (timer_expire) begin
			enable_q <= '0;
		end
	end

	// outputs registered, so they trail the enable word by one cycle
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			o_balance_output <= '0;
			o_squeeze_output <= '0;
		end else if (squeeze_q) begin
			o_balance_output <= '0;
			o_squeeze_output <= enable_q;
		end else begin
			o_balance_output <= enable_q;
			o_squeeze_output <= '0;
		end
	end

	always_comb begin
		rd_data = '0;
		unique case (idx)
			`CBC_IDX_CONFIG: rd_data[7:0] = config_q;
			`CBC_IDX_ENABLE: rd_data[15:0] = enable_q;
			`CBC_IDX_TEST: rd_data[`CBC_SQUEEZE_BIT] = squeeze_q;
			`CBC_IDX_STATUS: begin
				rd_data[`CBC_ST_RUN_BIT]   = timer_running;
				rd_data[`CBC_ST_BLOCK_BIT] = fault_block;
				rd_data[`CBC_ST_CKSUM_BIT] = i_user_checksum_error_flag;
				rd_data[`CBC_ST_SEC_MSB:`CBC_ST_SEC_LSB] = elapsed;
			end
			default: rd_data = '0;
		endcase
	end

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			o_wb_dat <= '0;
		end else if (req && !i_wb_we) begin
			o_wb_dat <= rd_data;
		end else begin
			o_wb_dat <= '0;
		end
	end

	// prescaler restarts with the timer so a restart is a true zero
	cbc_tick #(
		.CYCLES    (TICK_CYCLES)
	) u_tick (
		.i_clock   (i_clock),
		.i_srst    (i_srst),
		.i_restart (restart),
		.i_run     (timer_running),
		.o_tick    (tick)
	);

	// enable and config writes reach the timer through restart, i_active and i_code; fault and expiry clears of enable_q reach it through i_active
	cbc_timer u_timer (
		.i_clock   (i_clock),
		.i_srst    (i_srst),
		.i_restart (restart),
		.i_active  (enable_q != '0),
		.i_code    (dur_code),
		.i_tick    (tick),
		.o_running (timer_running),
		.o_expire  (timer_expire),
		.o_elapsed (elapsed)
	);

	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (i_srst);

	a_fault_clears_en: assert property (
		fault_block |=> enable_q == '0
	) else $error("fault did not clear enables");

	a_keep_on_fault: assert property (
		fault_any && keep_on_fault && !wr_enable_ok && !timer_expire
		|=> $stable(enable_q)
	) else $error("enables changed by fault with keep set");

	a_blocked_write: assert property (
		wr_enable && fault_block |=> enable_q == '0 ##1 !timer_running
	) else $error("write accepted during fault");

	a_config_rsvd_zero: assert property (
		req && !i_wb_we && idx == `CBC_IDX_CONFIG
		|=> o_wb_ack && o_wb_dat[2:0] == 3'h0
	) else $error("reserved config bits read nonzero");

	a_balance_map: assert property (
		!squeeze_q |=> o_balance_output == $past(enable_q) && o_squeeze_output == '0
	) else $error("balance outputs do not follow enables");

	a_squeeze_map: assert property (
		squeeze_q |=> o_squeeze_output == $past(enable_q) && o_balance_output == '0
	) else $error("squeeze outputs do not follow enables");

	a_expire_clears: assert property (
		timer_expire && !wr_enable_ok |=> enable_q == '0
	) else $error("expiry did not clear enables");

	a_restart_zero: assert property (
		restart |=> elapsed == '0 ##1 !timer_expire
	) else $error("timer not restarted by write");

	a_no_timed_code: assert property (
		timer_expire |-> $past(dur_limit) != '0
	) else $error("expiry with timer disabled");

	a_duration_limit: assert property (
		timer_expire
		|-> ($past(elapsed) + `CBC_SEC_W'(1)) >= $past(dur_limit)
	) else $error("expiry before selected duration");

	// a done timer may pass through run for one cycle on a restart
	a_untimed_idle: assert property (
		dur_limit == '0 && !restart |=> !timer_running
	) else $error("timer running with untimed code");

	a_ack_after_req: assert property (
		req |=> o_wb_ack
	) else $error("request not acknowledged");

	a_read_zero_idle: assert property (
		!o_wb_ack |-> o_wb_dat == '0
	) else $error("read data outside ack cycle");

	a_write_lands: assert property (
		wr_enable_ok |=> enable_q == $past(enable_merged)
	) else $error("accepted enable write lost");

	// checksum flag alone must never disturb the enables
	a_cksum_ignored: assert property (
		!fault_any && !wr_enable_ok && !timer_expire |=> $stable(enable_q)
	) else $error("enables changed without fault");

	a_squeeze_write: assert property (
		wr_test |=> squeeze_q == $past(i_wb_dat[`CBC_SQUEEZE_BIT])
	) else $error("squeeze mode write lost");

	a_restart_tick: assert property (
		restart |=> !tick
	) else $error("tick not cleared by restart");

	a_ack_one_cycle: assert property (
		o_wb_ack |=> !o_wb_ack
	) else $error("ack held for more than one cycle");

	c_expire: cover property (timer_expire ##1 enable_q == '0);
	c_fault_clear: cover property (fault_block && enable_q != '0);
	c_squeeze_on: cover property (squeeze_q && o_squeeze_output != '0);
	c_restart_run: cover property (restart && timer_running);
	c_blocked_write: cover property (wr_enable && fault_block);
endmodule : cbc_top

// ---- tb/cbc_switch_model.sv ----
// behavioural model of the external balance and squeeze switches
`timescale 1ns/1ps
module cbc_switch_model
	import cbc_pkg::*;
(
	// switch drives
	input  wire cbc_chan_t i_balance,
	input  wire cbc_chan_t i_squeeze,
	// drain seen across each cell
	output cbc_chan_t      o_drain
);
	// a cell drains while either switch of its channel conducts
	assign o_drain = i_balance | i_squeeze;
endmodule : cbc_switch_model

// ---- tb/tb.sv ----
// self-checking bench of the cell balance control block
`timescale 1ns/1ps
module tb;
	import cbc_pkg::*;
	// short tick keeps the 60 min code inside the run
	localparam int TK = 2;
	logic        clk;
	logic        srst;
	logic        cyc;
	logic        stb;
	logic        we;
	logic        ack;
	logic        cks;
	logic [3:0]  sel;
	logic [7:0]  adr;
	logic [7:0]  flt;
	logic [31:0] wdat;
	logic [31:0] rdat;
	logic [31:0] d;
	cbc_chan_t   bal;
	cbc_chan_t   sqz;
	cbc_chan_t   drain;
	int          failures;
	int          check_count;
	int          lim [1:9] = '{1, 60, 120, 300, 600, 900, 1200, 1800, 3600};

	cbc_top #(.TICK_CYCLES(TK)) i_dut (
		.i_clock(clk), .i_srst(srst), .i_wb_cyc(cyc), .i_wb_stb(stb),
		.i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
		.o_wb_ack(ack), .o_wb_dat(rdat), .i_fault_flags(flt),
		.i_user_checksum_error_flag(cks), .o_balance_output(bal),
		.o_squeeze_output(sqz));
	cbc_switch_model i_sw (.i_balance(bal), .i_squeeze(sqz), .o_drain(drain));

	task automatic end_of_test;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : end_of_test

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk

	task automatic chk_dur(input int n, input int lo, input int hi);
		check_count++;
		if (n < lo || n > hi) begin
			failures++;
			$display("Error at %0t: stop after %0d cycles", $time, n);
		end
	endtask : chk_dur

	// one classic cycle; waits for ack under a bound
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] v);
		int k;
		k = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= v;
		do begin
			@(posedge clk);
			k++;
		end while (ack !== 1'b1 && k < 50);
		if (ack !== 1'b1) begin
			failures++;
			$display("Error at %0t: no ack", $time);
		end
		d = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask : wb

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk(d, e);
	endtask : rd

	task automatic outs(input cbc_chan_t b, input cbc_chan_t s);
		repeat (2) @(posedge clk);
		chk({bal, sqz}, {b, s});
		chk({16'h0000, drain}, {16'h0000, b | s});
	endtask : outs

	task automatic measure(output int n);
		n = 0;
		// outputs trail the enable word by one edge
		@(posedge clk);
		while (bal !== 16'h0000 && n < 8000) begin
			@(posedge clk);
			n++;
		end
	endtask : measure

	task automatic t_reset;
		rd(8'h4C, 32'h0);
		rd(8'h50, 32'h0);
		rd(8'hA0, 32'h0);
		wb(1'b1, 8'h4C, 32'h98);
		rd(8'h4C, 32'h98);
		wb(1'b1, 8'h4C, 32'h00);
	endtask : t_reset

	task automatic t_squeeze;
		wb(1'b1, 8'h50, 32'h8001);
		outs(16'h8001, 16'h0000);
		wb(1'b1, 8'h78, 32'h10);
		outs(16'h0000, 16'h8001);
		wb(1'b1, 8'h78, 32'h00);
		outs(16'h8001, 16'h0000);
		wb(1'b1, 8'h50, 32'h0);
		outs(16'h0000, 16'h0000);
	endtask : t_squeeze

	task automatic t_fault;
		wb(1'b1, 8'h50, 32'h00F0);
		flt <= 8'h04;
		repeat (3) @(posedge clk);
		rd(8'h50, 32'h0);
		wb(1'b1, 8'h50, 32'h0F00);
		rd(8'h50, 32'h0);
		flt <= 8'h00;
		cks <= 1'b1;
		wb(1'b1, 8'h50, 32'h0F00);
		repeat (3) @(posedge clk);
		rd(8'h50, 32'h0F00);
		rd(8'hFC, 32'h4);
		wb(1'b1, 8'h4C, 32'h08);
		flt <= 8'h80;
		repeat (3) @(posedge clk);
		rd(8'h50, 32'h0F00);
		flt <= 8'h00;
		cks <= 1'b0;
		wb(1'b1, 8'h50, 32'h0);
		wb(1'b1, 8'h4C, 32'h00);
	endtask : t_fault

	// every documented duration code, whole expiry each time
	task automatic t_timed;
		int n;
		for (int c = 1; c <= 9; c++) begin
			wb(1'b1, 8'h4C, 32'(c << 4));
			wb(1'b1, 8'h50, 32'hFFFF);
			measure(n);
			chk_dur(n, lim[c] * TK - 2, lim[c] * TK + 8);
			rd(8'h50, 32'h0);
		end
	endtask : t_timed

	// rewrite mid-run restarts; a read in between does not
	task automatic t_restart;
		int n;
		wb(1'b1, 8'h4C, 32'h20);
		wb(1'b1, 8'h50, 32'h0003);
		repeat (80) @(posedge clk);
		wb(1'b1, 8'h50, 32'h0003);
		repeat (30) @(posedge clk);
		rd(8'h50, 32'h0003);
		measure(n);
		chk_dur(n, 120 - 38, 120 - 24);
	endtask : t_restart

	task automatic t_untimed;
		logic [3:0] cd [3] = '{4'h0, 4'hA, 4'hF};
		foreach (cd[i]) begin
			wb(1'b1, 8'h4C, {24'h0, cd[i], 4'h0});
			wb(1'b1, 8'h50, 32'h5A5A);
			repeat (300) @(posedge clk);
			chk({16'h0000, bal}, 32'h5A5A);
			wb(1'b1, 8'h50, 32'h0);
		end
	endtask : t_untimed

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	initial begin
		#3000000;
		failures++;
		end_of_test();
	end

	initial begin
		failures = 0;
		check_count = 0;
		srst = 1'b1;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		cks = 1'b0;
		sel = 4'h3;
		adr = 8'h00;
		flt = 8'h00;
		wdat = 32'h0;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		t_reset();
		t_squeeze();
		t_fault();
		t_timed();
		t_restart();
		t_untimed();
		end_of_test();
	end
endmodule : tb
